// *** src/motion_cfg_pkg.sv ***
/*
 * Holds the offsets, field positions, reset values and carrier types of the
 * two indirectly reached configuration banks of the motion signal path.
 * Assumes an indirect-access engine elsewhere presents one register
 * request per cycle, in the main clock domain.
 */
package motion_cfg_pkg;

   // ==========================================================
   // Bank layout
   // ==========================================================
   localparam int GYRO_REG_COUNT = 11;
   localparam int ACCEL_REG_COUNT = 12;
   localparam logic BANK_GYRO = 1'h0;
   localparam logic BANK_ACCEL = 1'h1;

   // Gyro bank slot indices
   localparam int G_XLO = 0;
   localparam int G_XHI = 1;
   localparam int G_YLO = 2;
   localparam int G_YHI = 3;
   localparam int G_ZLO = 4;
   localparam int G_ZHI = 5;
   localparam int G_SRC = 6;
   localparam int G_NOTCH = 7;
   localparam int G_HPAVG = 8;
   localparam int G_AUXLP = 9;
   localparam int G_UILP = 10;

   // Accel bank slot indices
   localparam int A_XLO = 0;
   localparam int A_XHI = 1;
   localparam int A_YLO = 2;
   localparam int A_YHI = 3;
   localparam int A_ZLO = 4;
   localparam int A_ZHI = 5;
   localparam int A_SRC = 6;
   localparam int A_TEMP = 7;
   localparam int A_HPAVG = 8;
   localparam int A_AUXLP = 9;
   localparam int A_UILP = 10;
   localparam int A_BYP = 11;

   // Register offsets, in slot order
   localparam logic [7:0] GYRO_OFFS [GYRO_REG_COUNT] = '{
      8'h2A, 8'h2B, 8'h38, 8'h39, 8'h46, 8'h47, 8'hA6, 8'hA8, 8'hAA, 8'hAB, 8'hAC};
   localparam logic [7:0] ACCEL_OFFS [ACCEL_REG_COUNT] = '{
      8'h18, 8'h19, 8'h20, 8'h21, 8'h28, 8'h29, 8'h7B, 8'h80, 8'h81, 8'h82, 8'h83,
      8'h84};

   // Reset values, in slot order
   localparam logic [7:0] GYRO_RST [GYRO_REG_COUNT] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1B, 8'h06, 8'h0A, 8'h09, 8'h80};
   localparam logic [7:0] ACCEL_RST [ACCEL_REG_COUNT] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h34, 8'h00, 8'h02, 8'h00, 8'h00,
      8'h03};

   // Storable bits; offset high bytes keep only bits 5:0
   localparam logic [7:0] GYRO_MASK [GYRO_REG_COUNT] = '{
      8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [7:0] ACCEL_MASK [ACCEL_REG_COUNT] = '{
      8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF};

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int OFS_HI_MSB = 5;
   localparam int G_SRC_LSB = 5;
   localparam int A_SRC_LSB = 0;
   localparam int G_NOTCH_BIT = 1;
   localparam int G_STAB_HP_LSB = 5;
   localparam int G_AVG_LSB = 1;
   localparam int A_STAB_HP_LSB = 4;
   localparam int A_AVG_LSB = 0;
   localparam int AUX_LP_LSB = 0;
   localparam int G_AUX_HP_BYP_BIT = 7;
   localparam int G_UI_BYP_BIT = 4;
   localparam int A_UI_BYP_BIT = 5;
   localparam int UI_LP_LSB = 0;
   localparam int A_AUX_HP_BYP_BIT = 0;
   localparam int A_NOTCH_BIT = 2;
   localparam int TEMP_DEC_LSB = 3;
   localparam int TEMP_LP_LSB = 0;

   // ==========================================================
   // Codes
   // ==========================================================
   localparam logic [2:0] STAB_HP_BYPASS = 3'h0;
   localparam logic [2:0] STAB_HP_MAX = 3'h4;
   localparam logic [2:0] STAB_HP_RSVD = 3'h1;
   localparam logic [3:0] AVG_MAX_CODE = 4'hC;

   typedef enum logic [1:0] {
      SRC_ALL_OFF,
      SRC_FIR_ONLY,
      SRC_INTERP_FIR,
      SRC_DEBUG
   } src_mode_e;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic bank;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic signed [13:0] x_offset;
      logic signed [13:0] y_offset;
      logic signed [13:0] z_offset;
      src_mode_e src_mode;
      logic interp_en;
      logic fir_en;
      logic stab_notch_bypass;
      logic [2:0] stab_highpass_bw;
      logic stab_highpass_code_bad;
      logic [6:0] avg_samples;
      logic avg_code_bad;
      logic [2:0] aux_lowpass_bw;
      logic aux_highpass_bypass;
      logic ui_lowpass_bypass;
      logic [2:0] ui_lowpass_div_log2;
      logic bw_fir_and_ui;
   } axis_cfg_s;

   typedef struct packed {
      logic [7:0] decimation;
      logic [2:0] lowpass_bw;
   } temp_cfg_s;

endpackage

// *** src/motion_signal_path_config_bank.sv ***
/*
 * Two indirectly reached banks of 8-bit configuration registers for the
 * gyro and accel signal paths, plus decoded settings for the datapath.
 * Assumes the indirect-access engine drives i_req synchronously to i_mclk
 * and that the filter datapaths consume the decoded settings.
 */
`timescale 1ns/1ps

// Function
// R01 - Gyro axis offsets are 14 bits: low byte, then upper six bits 5:0.
// R02 - Accel axis offsets are 14 bits: low byte, then upper six bits.
// R03 - Gyro rate converter bits 6:5: off, FIR only, interp+FIR, debug.
// R04 - Accel rate converter bits 1:0 use the same four codes.
// R05 - Gyro stabilisation-path notch bypassed while bit 1 is set.
// R06 - Stabilisation highpass select: bypass, 0.25, 0.062, 0.016 Hz; rest reserved.
// R07 - Gyro averaging bits 4:1 choose 1 to 64 samples over codes 0..12.
// R08 - Accel averaging bits 3:0 use the same sample-count table.
// R09 - Aux lowpass select: bypass then 1100..65 Hz; codes 6 and 7 both 65 Hz.
// R10 - Gyro aux highpass bypassed while bit 7 is set.
// R11 - Accel aux highpass bypassed while bit 0 is set.
// R12 - Accel stabilisation-path notch bypassed while bit 2 is set.
// R13 - Gyro UI lowpass bypassed on all axes while bit 4 is set.
// R14 - Accel UI lowpass bypassed on all axes while bit 5 is set.
// R15 - UI lowpass select: bypass, ODR/4 to ODR/128; code 7 also ODR/128.
// R16 - With the FIR on, bandwidth comes from FIR and UI lowpass together.
// R17 - Temperature decimation bits 5:3: bypass, then 2 up to 128.
// R18 - Temperature lowpass: bypass, 25% down to 1% of ODR; 7 also 1%.
// R19 - Banks reached only through the indirect access procedure.
// R20 - Offsets are signed two's complement, added after scaling.
// R21 - Host programs no reserved codes and writes zeros to reserved bits.
module motion_signal_path_config_bank
   import motion_cfg_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Indirect access request
   input wire reg_req_s i_req,
   // Read answer
   output logic [7:0] o_rdata,
   output logic o_rd_valid,
   output logic o_addr_err,
   // Decoded settings
   output axis_cfg_s o_gyro_cfg,
   output axis_cfg_s o_accel_cfg,
   output temp_cfg_s o_temp_cfg
);

   // ==========================================================
   // Helpers
   // ==========================================================

   // Slot lookup; returns -1 for an unmapped offset
   function automatic int gyro_slot(input logic [7:0] addr);
      int slot;
      slot = -1;
      for (int i = 0; i < GYRO_REG_COUNT; i++) begin
         if (GYRO_OFFS[i] == addr) begin
            slot = i;
         end
      end
      return slot;
   endfunction

   function automatic int accel_slot(input logic [7:0] addr);
      int slot;
      slot = -1;
      for (int i = 0; i < ACCEL_REG_COUNT; i++) begin
         if (ACCEL_OFFS[i] == addr) begin
            slot = i;
         end
      end
      return slot;
   endfunction

   // Averaging code to sample count; reserved codes fall back to 1
   function automatic logic [6:0] avg_samples(input logic [3:0] code);
      logic [6:0] n;
      n = 7'h01;
      case (code)
         4'h0: n = 7'h01;
         4'h1: n = 7'h02;
         4'h2: n = 7'h04;
         4'h3: n = 7'h05;
         4'h4: n = 7'h07;
         4'h5: n = 7'h08;
         4'h6: n = 7'h0A;
         4'h7: n = 7'h0B;
         4'h8: n = 7'h10;
         4'h9: n = 7'h12;
         4'hA: n = 7'h14;
         4'hB: n = 7'h20;
         4'hC: n = 7'h40;
         default: n = 7'h01;
      endcase
      return n;
   endfunction

   // Highpass code is reserved unless bypass or 2..4
   function automatic logic stab_hp_bad(input logic [2:0] code);
      return (code == STAB_HP_RSVD) || (code > STAB_HP_MAX);
   endfunction

   // Lowpass code to log2 of ODR divider; 0 means bypass, 7 folds onto 6
   function automatic logic [2:0] ui_div_log2(input logic [2:0] code);
      logic [2:0] d;
      d = 3'h0;
      if (code == 3'h0) begin
         d = 3'h0;
      end else if (code == 3'h7) begin
         d = 3'h7;
      end else begin
         d = code + 3'h1;
      end
      return d;
   endfunction

   // Seven-code aux lowpass, code 7 is the same 65 Hz corner as code 6
   function automatic logic [2:0] aux_lp_fold(input logic [2:0] code);
      return (code == 3'h7) ? 3'h6 : code;
   endfunction

   // Rate converter decode shared by both sensors
   function automatic src_mode_e src_decode(input logic [1:0] code);
      return src_mode_e'(code);
   endfunction

   // Decimation code to factor, 0 means bypass (factor 1)
   function automatic logic [7:0] temp_dec(input logic [2:0] code);
      return 8'h01 << code;
   endfunction

   // ==========================================================
   // Register storage
   // ==========================================================
   logic [7:0] gyro_r [GYRO_REG_COUNT];
   logic [7:0] accel_r [ACCEL_REG_COUNT];
   int req_gslot;
   int req_aslot;
   logic req_hit;

   // Reaching these slots needs the indirect engine; no direct address path
   always_comb begin
      req_gslot = gyro_slot(i_req.addr); // R19
      req_aslot = accel_slot(i_req.addr); // R19
      if (i_req.bank == BANK_GYRO) begin
         req_hit = (req_gslot >= 0);
      end else begin
         req_hit = (req_aslot >= 0);
      end
   end

   // Gyro bank writes; bits outside the mask stay zero
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         for (int i = 0; i < GYRO_REG_COUNT; i++) begin
            gyro_r[i] <= GYRO_RST[i];
         end
      end else if (i_req.wr && i_req.bank == BANK_GYRO && req_gslot >= 0) begin
         gyro_r[req_gslot] <= i_req.wdata & GYRO_MASK[req_gslot]; // R01
      end
   end

   // Accel bank writes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         for (int i = 0; i < ACCEL_REG_COUNT; i++) begin
            accel_r[i] <= ACCEL_RST[i];
         end
      end else if (i_req.wr && i_req.bank == BANK_ACCEL && req_aslot >= 0) begin
         accel_r[req_aslot] <= i_req.wdata & ACCEL_MASK[req_aslot]; // R02
      end
   end

   // ==========================================================
   // Read answer
   // ==========================================================

   // Answer one cycle after the request; unmapped reads return zero
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
         o_rd_valid <= 1'b0;
         o_addr_err <= 1'b0;
      end else begin
         o_rd_valid <= i_req.rd;
         o_addr_err <= (i_req.rd || i_req.wr) && !req_hit;
         if (i_req.rd && req_hit) begin
            o_rdata <= (i_req.bank == BANK_GYRO) ? gyro_r[req_gslot] : accel_r[req_aslot];
         end else if (i_req.rd) begin
            o_rdata <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Gyro decode
   // ==========================================================
   src_mode_e g_src;
   assign g_src = src_decode(gyro_r[G_SRC][G_SRC_LSB +: 2]); // R03

   // Settings reach the datapath one cycle after the write lands
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_gyro_cfg <= '0;
      end else begin
         // Signed two's complement; scaling happens in the datapath
         o_gyro_cfg.x_offset <= {gyro_r[G_XHI][OFS_HI_MSB:0], gyro_r[G_XLO]}; // R20
         o_gyro_cfg.y_offset <= {gyro_r[G_YHI][OFS_HI_MSB:0], gyro_r[G_YLO]}; // R01
         o_gyro_cfg.z_offset <= {gyro_r[G_ZHI][OFS_HI_MSB:0], gyro_r[G_ZLO]}; // R01
         o_gyro_cfg.src_mode <= g_src; // R03
         o_gyro_cfg.interp_en <= (g_src == SRC_INTERP_FIR); // R03
         o_gyro_cfg.fir_en <= (g_src == SRC_FIR_ONLY) || (g_src == SRC_INTERP_FIR); // R03
         o_gyro_cfg.stab_notch_bypass <= gyro_r[G_NOTCH][G_NOTCH_BIT]; // R05
         o_gyro_cfg.stab_highpass_bw <= gyro_r[G_HPAVG][G_STAB_HP_LSB +: 3]; // R06
         o_gyro_cfg.stab_highpass_code_bad <= stab_hp_bad(gyro_r[G_HPAVG][G_STAB_HP_LSB +: 3]); // R06
         o_gyro_cfg.avg_samples <= avg_samples(gyro_r[G_HPAVG][G_AVG_LSB +: 4]); // R07
         o_gyro_cfg.avg_code_bad <= gyro_r[G_HPAVG][G_AVG_LSB +: 4] > AVG_MAX_CODE; // R07
         o_gyro_cfg.aux_lowpass_bw <= aux_lp_fold(gyro_r[G_AUXLP][AUX_LP_LSB +: 3]); // R09
         o_gyro_cfg.aux_highpass_bypass <= gyro_r[G_UILP][G_AUX_HP_BYP_BIT]; // R10
         o_gyro_cfg.ui_lowpass_bypass <= gyro_r[G_UILP][G_UI_BYP_BIT]; // R13
         o_gyro_cfg.ui_lowpass_div_log2 <= ui_div_log2(gyro_r[G_UILP][UI_LP_LSB +: 3]); // R15
         // FIR and UI lowpass together set the bandwidth while FIR runs and the UI lowpass is not bypassed
         o_gyro_cfg.bw_fir_and_ui <= (g_src == SRC_FIR_ONLY || g_src == SRC_INTERP_FIR)
            && !gyro_r[G_UILP][G_UI_BYP_BIT]; // R16
      end
   end

   // ==========================================================
   // Accel decode
   // ==========================================================
   src_mode_e a_src;
   assign a_src = src_decode(accel_r[A_SRC][A_SRC_LSB +: 2]); // R04

   // Same shape as the gyro decode, different field positions
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_accel_cfg <= '0;
      end else begin
         o_accel_cfg.x_offset <= {accel_r[A_XHI][OFS_HI_MSB:0], accel_r[A_XLO]}; // R02
         o_accel_cfg.y_offset <= {accel_r[A_YHI][OFS_HI_MSB:0], accel_r[A_YLO]}; // R02
         o_accel_cfg.z_offset <= {accel_r[A_ZHI][OFS_HI_MSB:0], accel_r[A_ZLO]}; // R20
         o_accel_cfg.src_mode <= a_src; // R04
         o_accel_cfg.interp_en <= (a_src == SRC_INTERP_FIR); // R04
         o_accel_cfg.fir_en <= (a_src == SRC_FIR_ONLY) || (a_src == SRC_INTERP_FIR); // R04
         o_accel_cfg.stab_notch_bypass <= accel_r[A_BYP][A_NOTCH_BIT]; // R12
         o_accel_cfg.stab_highpass_bw <= accel_r[A_HPAVG][A_STAB_HP_LSB +: 3]; // R06
         o_accel_cfg.stab_highpass_code_bad <= stab_hp_bad(accel_r[A_HPAVG][A_STAB_HP_LSB +: 3]); // R06
         o_accel_cfg.avg_samples <= avg_samples(accel_r[A_HPAVG][A_AVG_LSB +: 4]); // R08
         o_accel_cfg.avg_code_bad <= accel_r[A_HPAVG][A_AVG_LSB +: 4] > AVG_MAX_CODE; // R08
         o_accel_cfg.aux_lowpass_bw <= aux_lp_fold(accel_r[A_AUXLP][AUX_LP_LSB +: 3]); // R09
         o_accel_cfg.aux_highpass_bypass <= accel_r[A_BYP][A_AUX_HP_BYP_BIT]; // R11
         o_accel_cfg.ui_lowpass_bypass <= accel_r[A_UILP][A_UI_BYP_BIT]; // R14
         o_accel_cfg.ui_lowpass_div_log2 <= ui_div_log2(accel_r[A_UILP][UI_LP_LSB +: 3]); // R15
         o_accel_cfg.bw_fir_and_ui <= (a_src == SRC_FIR_ONLY || a_src == SRC_INTERP_FIR)
            && !accel_r[A_UILP][A_UI_BYP_BIT]; // R16
      end
   end

   // ==========================================================
   // Temperature decode
   // ==========================================================

   // Decimation sets the temperature processing rate; lowpass 7 folds to 6
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_temp_cfg <= '0;
      end else begin
         o_temp_cfg.decimation <= temp_dec(accel_r[A_TEMP][TEMP_DEC_LSB +: 3]); // R17
         o_temp_cfg.lowpass_bw <= aux_lp_fold(accel_r[A_TEMP][TEMP_LP_LSB +: 3]); // R18
      end
   end

endmodule // motion_signal_path_config_bank

// *** verification/motion_signal_path_config_bank_props.sv ***
/* Checker for the configuration bank; sees only the bank's ports.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
module motion_signal_path_config_bank_props
   import motion_cfg_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Watched ports
   input wire reg_req_s i_req,
   input wire logic [7:0] o_rdata,
   input wire logic o_rd_valid,
   input wire logic o_addr_err,
   input wire axis_cfg_s o_gyro_cfg,
   input wire axis_cfg_s o_accel_cfg,
   input wire temp_cfg_s o_temp_cfg
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // ==========================================================
   // Read answers, one cycle after the taking edge
   // ==========================================================
   rd_answer_a: assert property (o_rd_valid == $past(i_req.rd)) else $error("read answer late");
   err_unmapped_a: assert property (i_req.rd && !i_req.bank && i_req.addr == 8'h00
      |=> o_addr_err && o_rdata == 8'h00) else $error("unmapped read not flagged");
   map_no_err_a: assert property ((i_req.rd || i_req.wr) && !i_req.bank && i_req.addr == 8'h2A
      |=> !o_addr_err) else $error("mapped access flagged");
   hi_reserved_a: assert property (i_req.rd && !i_req.bank && i_req.addr == 8'h2B
      |=> o_rdata[7:6] == 2'h0) else $error("offset high reserved bits set");

   // ==========================================================
   // Bypass bits reach the decoded settings two edges after a write
   // ==========================================================
   g_notch_a: assert property (i_req.wr && !i_req.bank && i_req.addr == 8'hA8 |-> ##2
      o_gyro_cfg.stab_notch_bypass == $past(i_req.wdata[1], 2)) else $error("gyro notch");
   g_auxhp_a: assert property (i_req.wr && !i_req.bank && i_req.addr == 8'hAC |-> ##2
      o_gyro_cfg.aux_highpass_bypass == $past(i_req.wdata[7], 2)) else $error("gyro aux hp");
   g_uibyp_a: assert property (i_req.wr && !i_req.bank && i_req.addr == 8'hAC |-> ##2
      o_gyro_cfg.ui_lowpass_bypass == $past(i_req.wdata[4], 2)) else $error("gyro ui lp");
   a_auxhp_a: assert property (i_req.wr && i_req.bank && i_req.addr == 8'h84 |-> ##2
      o_accel_cfg.aux_highpass_bypass == $past(i_req.wdata[0], 2)) else $error("acc aux hp");
   a_notch_a: assert property (i_req.wr && i_req.bank && i_req.addr == 8'h84 |-> ##2
      o_accel_cfg.stab_notch_bypass == $past(i_req.wdata[2], 2)) else $error("acc notch");
   a_uibyp_a: assert property (i_req.wr && i_req.bank && i_req.addr == 8'h83 |-> ##2
      o_accel_cfg.ui_lowpass_bypass == $past(i_req.wdata[5], 2)) else $error("acc ui lp");

   // ==========================================================
   // Rate converter decode; debug code left open on purpose in the enable checks
   // ==========================================================
   g_fir_a: assert property (o_gyro_cfg.src_mode != SRC_DEBUG |-> o_gyro_cfg.fir_en ==
      (o_gyro_cfg.src_mode != SRC_ALL_OFF)) else $error("gyro fir enable");
   a_interp_a: assert property (o_accel_cfg.src_mode != SRC_DEBUG |-> o_accel_cfg.interp_en ==
      (o_accel_cfg.src_mode == SRC_INTERP_FIR)) else $error("accel interpolator");
   fir_bw_a: assert property (o_gyro_cfg.bw_fir_and_ui ==
      (o_gyro_cfg.fir_en && !o_gyro_cfg.ui_lowpass_bypass)) else $error("bandwidth mix");
endmodule // motion_signal_path_config_bank_props

bind motion_signal_path_config_bank motion_signal_path_config_bank_props
   u_motion_signal_path_config_bank_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
   .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_addr_err(o_addr_err),
   .o_gyro_cfg(o_gyro_cfg), .o_accel_cfg(o_accel_cfg), .o_temp_cfg(o_temp_cfg));

// *** verification/host_model.sv ***
/* Host that reaches the banks through indirect register requests.
   Assumes the bench calls op only after reset has been released. */
`timescale 1ns/1ps
module host_model
   import motion_cfg_pkg::*;
(
   // Clock
   input wire logic i_mclk,
   // Request and answer
   output reg_req_s o_req,
   input wire logic [7:0] i_rdata,
   input wire logic i_rd_valid,
   input wire logic i_addr_err
);
   // Idle request at time zero
   initial o_req = '0;

   // One transfer held over one rising edge; answer is registered so it is
   // taken at the next falling edge. Released address and data are inverted and
   // wr and rd cleared, so stale fields never pass as live.
   task automatic op(input logic b, input logic w, input logic r, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic v, output logic e);
      @(negedge i_mclk);
      o_req = '{bank: b, wr: w, rd: r, addr: a, wdata: d};
      @(negedge i_mclk);
      q = i_rdata;
      v = i_rd_valid;
      e = i_addr_err;
      o_req = '{bank: b, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule // host_model

// *** verification/motion_signal_path_config_bank_tb.sv ***
/* Self-checking bench for the configuration bank.
   Assumes the host model drives requests and the checker is bound. */
`timescale 1ns/1ps
module motion_signal_path_config_bank_tb
   import motion_cfg_pkg::*;
;
   logic i_mclk;
   logic i_rst_n;
   reg_req_s req;
   logic [7:0] rdata;
   logic rd_valid;
   logic addr_err;
   axis_cfg_s gcfg;
   axis_cfg_s acfg;
   temp_cfg_s tcfg;
   logic [7:0] q;
   logic v;
   logic e;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [6:0] avg_tab [13] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h07, 7'h08, 7'h0A, 7'h0B,
      7'h10, 7'h12, 7'h14, 7'h20, 7'h40};

   // ==========================================================
   // Clock, design and host
   // ==========================================================
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   motion_signal_path_config_bank u_motion_signal_path_config_bank (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata), .o_rd_valid(rd_valid),
      .o_addr_err(addr_err), .o_gyro_cfg(gcfg), .o_accel_cfg(acfg), .o_temp_cfg(tcfg));
   host_model u_host_model (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata),
      .i_rd_valid(rd_valid), .i_addr_err(addr_err));

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   // Extra cycle lets the decoded settings catch up with the write
   task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
      u_host_model.op(b, 1'b1, 1'b0, a, d, q, v, e);
      @(negedge i_mclk);
   endtask
   task automatic rd(input logic b, input logic [7:0] a);
      u_host_model.op(b, 1'b0, 1'b1, a, 8'h00, q, v, e);
      chk("rd_valid", 16'(v), 16'h1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      for (int i = 0; i < ACCEL_REG_COUNT; i++) begin
         if (i < GYRO_REG_COUNT) begin
            rd(BANK_GYRO, GYRO_OFFS[i]);
            chk("g_rst", 16'(q), 16'(GYRO_RST[i]));
         end
         rd(BANK_ACCEL, ACCEL_OFFS[i]);
         chk("a_rst", 16'(q), 16'(ACCEL_RST[i]));
      end
   endtask
   // High byte keeps bits 5:0 only; value seen sign-extended
   task automatic t_offs();
      logic [7:0] lo;
      logic [7:0] a;
      axis_cfg_s s;
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 3; i++) begin
            lo = 8'hA5 + 8'(i);
            a = b ? ACCEL_OFFS[2 * i] : GYRO_OFFS[2 * i];
            wr(1'(b), a, lo);
            wr(1'(b), a + 8'h01, 8'hE0 + 8'(i));
            rd(1'(b), a + 8'h01);
            chk("ofs_hi", 16'(q), 16'(8'h20 + 8'(i)));
            s = b ? acfg : gcfg;
            chk("ofs", 16'(i == 0 ? s.x_offset : i == 1 ? s.y_offset : s.z_offset),
               {8'hE0 + 8'(i), lo});
         end
      end
   endtask
   // Gyro UI bypass is still clear from reset here
   task automatic t_src();
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         wr(BANK_GYRO, 8'hA6, {1'b0, c, 5'h00});
         wr(BANK_ACCEL, 8'h7B, {6'h00, c});
         chk("g_src", 16'(gcfg.src_mode), 16'(c));
         chk("a_src", 16'(acfg.src_mode), 16'(c));
         if (c != 2'h3) begin
            chk("g_fir", 16'(gcfg.fir_en), 16'(c != 2'h0));
            chk("a_int", 16'(acfg.interp_en), 16'(c == 2'h2));
            chk("bw_mix", 16'(gcfg.bw_fir_and_ui), 16'(c != 2'h0));
            chk("g_int", 16'(gcfg.interp_en), 16'(c == 2'h2));
            chk("a_fir", 16'(acfg.fir_en), 16'(c != 2'h0));
            chk("a_bw_mix", 16'(acfg.bw_fir_and_ui), 16'(c != 2'h0));
         end
      end
   endtask
   task automatic t_fields();
      logic [2:0] c;
      logic [2:0] f;
      for (int i = 0; i < 14; i++) begin
         wr(BANK_GYRO, 8'hAA, 8'(i << 1));
         wr(BANK_ACCEL, 8'h81, 8'(i));
         if (i < 13) begin
            chk("g_avg", 16'(gcfg.avg_samples), 16'(avg_tab[i]));
            chk("a_avg", 16'(acfg.avg_samples), 16'(avg_tab[i]));
         end
         chk("g_avg_bad", 16'(gcfg.avg_code_bad), 16'(i > 12));
         chk("a_avg_bad", 16'(acfg.avg_code_bad), 16'(i > 12));
      end
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         f = (c == 3'h7) ? 3'h6 : c;
         wr(BANK_GYRO, 8'hAA, {c, 5'h00});
         wr(BANK_ACCEL, 8'h81, {1'b0, c, 4'h0});
         wr(BANK_GYRO, 8'hAB, {5'h00, c});
         wr(BANK_ACCEL, 8'h82, {5'h00, c});
         wr(BANK_GYRO, 8'hAC, {5'h00, c});
         wr(BANK_ACCEL, 8'h83, {5'h00, c});
         wr(BANK_ACCEL, 8'h80, {2'h0, c, c});
         chk("g_hp_bad", 16'(gcfg.stab_highpass_code_bad), 16'(c == 1 || c > 4));
         chk("a_hp_bad", 16'(acfg.stab_highpass_code_bad), 16'(c == 1 || c > 4));
         chk("hp_bw", 16'({gcfg.stab_highpass_bw, acfg.stab_highpass_bw}), 16'({c, c}));
         chk("g_aux_lp", 16'(gcfg.aux_lowpass_bw), 16'(f));
         chk("a_aux_lp", 16'(acfg.aux_lowpass_bw), 16'(f));
         chk("g_ui", 16'(gcfg.ui_lowpass_div_log2), 16'(c == 0 ? 0 : f + 1));
         chk("a_ui", 16'(acfg.ui_lowpass_div_log2), 16'(c == 0 ? 0 : f + 1));
         chk("t_dec", 16'(tcfg.decimation), 16'(1 << c));
         chk("t_lp", 16'(tcfg.lowpass_bw), 16'(f));
      end
   endtask
   task automatic t_bits();
      logic [7:0] d;
      for (int i = 0; i < 2; i++) begin
         d = i ? 8'h00 : 8'hFF;
         wr(BANK_GYRO, 8'hA8, d);
         wr(BANK_GYRO, 8'hAC, d);
         wr(BANK_ACCEL, 8'h84, d);
         wr(BANK_ACCEL, 8'h83, d);
         chk("g_notch", 16'(gcfg.stab_notch_bypass), 16'(d[0]));
         chk("g_auxhp", 16'(gcfg.aux_highpass_bypass), 16'(d[0]));
         chk("a_auxhp", 16'(acfg.aux_highpass_bypass), 16'(d[0]));
         chk("a_notch", 16'(acfg.stab_notch_bypass), 16'(d[0]));
         chk("g_uibyp", 16'(gcfg.ui_lowpass_bypass), 16'(d[0]));
         chk("a_uibyp", 16'(acfg.ui_lowpass_bypass), 16'(d[0]));
      end
   endtask
   // Unmapped access, read and write together, then a reset in mid-run
   task automatic t_err();
      u_host_model.op(BANK_GYRO, 1'b0, 1'b1, 8'h00, 8'h00, q, v, e);
      chk("err_rd", 16'({v, e, q}), 16'h0300);
      wr(BANK_ACCEL, 8'h01, 8'h55);
      chk("err_wr", 16'(e), 16'h1);
      wr(BANK_GYRO, 8'h2A, 8'h77);
      u_host_model.op(BANK_GYRO, 1'b1, 1'b1, 8'h2A, 8'h11, q, v, e);
      chk("rdwr_old", 16'(q), 16'h77);
      rd(BANK_GYRO, 8'h2A);
      chk("rdwr_new", 16'(q), 16'h11);
      i_rst_n = 1'b0;
      @(negedge i_mclk);
      i_rst_n = 1'b1;
      rd(BANK_GYRO, 8'h2A);
      chk("rst_again", 16'(q), 16'h00);
   endtask

   // ==========================================================
   // Main sequence and hang guard
   // ==========================================================
   initial begin
      i_rst_n = 1'b0;
      repeat (6) @(negedge i_mclk);
      i_rst_n = 1'b1;
      t_reset();
      t_offs();
      t_src();
      t_fields();
      t_bits();
      t_err();
      report_and_stop();
   end
   // Whole run needs well under a thousand cycles
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
endmodule // motion_signal_path_config_bank_tb
